// *** rtl/path_performance_counter_bank.sv ***
// Performance counter bank with leak rate and shared high byte latch
`timescale 1ns/1ns
`default_nettype none
module path_performance_counter_bank
   import perf_bank_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] cpu_addr_i,
   input wire logic [7:0] cpu_wdata_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   input wire logic frame_i,
   input wire logic path_inc_i,
   input wire logic path_dec_i,
   input wire logic path_ndf_i,
   input wire logic tug_inc_i,
   input wire logic tug_dec_i,
   input wire logic tug_ndf_i,
   input wire logic [9:0] tug_ptr_i,
   input wire logic b3_block_err_i,
   input wire logic g1_valid_i,
   input wire logic [3:0] g1_febe_i,
   input wire logic [3:0] b3_bit_errs_i,
   input wire logic coding_violation_i,
   input wire logic prbs_error_i,
   input wire logic analyzer_out_of_lock_i,
   input wire logic drop_clock_loss_alarm_i,
   input wire logic drop_path_start_loss_alarm_i,
   input wire logic tug_loss_of_pointer_i,
   input wire logic tug_path_ais_i,
   input wire logic e1_ais_i,
   input wire logic external_status_input_i,
   input wire logic path_alarm_input_i,
   output logic [7:0] cpu_rdata_o,
   output logic fifo_leak_o
);

   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] shared_high;
      logic [7:0] leak_rate;
      logic [9:0] leak_cnt;
      logic leak_pulse;
      logic [9:0] tug_prev;
      logic clear_on_read_select;
      logic far_end_block_mode;
      logic pattern_analyzer_enable;
      logic external_alarm_select;
      logic global_counter_reset;
   } bank_state_t;

   bank_state_t st, next_st;

   logic [7:0] c8 [N8];
   logic [15:0] c16 [N16];
   logic [3:0] amt8 [N8];
   logic [3:0] amt16 [N16];
   logic rd8 [N8];
   logic wr8 [N8];
   logic rd_lo [N16];
   logic rd_hi [N16];
   logic wr_lo [N16];
   logic wr_hi [N16];
   logic drop_inhibit;
   logic lo_hit;
   logic [7:0] lo_high;
   logic [1:0] tug_ndf_amt;
   logic [9:0] leak_period;

   // Drop-side alarm gate; the line side counter is not gated
   always_comb begin
      drop_inhibit = drop_clock_loss_alarm_i
         | drop_path_start_loss_alarm_i
         | tug_loss_of_pointer_i
         | tug_path_ais_i;
      if (st.external_alarm_select) begin
         drop_inhibit = drop_inhibit | external_status_input_i
            | path_alarm_input_i;
      end else begin
         drop_inhibit = drop_inhibit | e1_ais_i;
      end
   end

   // Pointer moves 192 to 194 and 193 to 195 are not seen as new pointers; the reverse moves count as two
   always_comb begin
      tug_ndf_amt = 2'h1;
      if ((st.tug_prev == TUG_PTR_192 && tug_ptr_i == TUG_PTR_194) ||
          (st.tug_prev == TUG_PTR_193 && tug_ptr_i == TUG_PTR_195)) begin
         tug_ndf_amt = 2'h0;
      end else if ((st.tug_prev == TUG_PTR_194 &&
                    tug_ptr_i == TUG_PTR_192) ||
                   (st.tug_prev == TUG_PTR_195 &&
                    tug_ptr_i == TUG_PTR_193)) begin
         tug_ndf_amt = 2'h2;
      end
   end

   always_comb begin
      amt8[C_FRAME] = {3'h0, frame_i};
      amt8[C_PATH_INC] = {3'h0, path_inc_i};
      amt8[C_PATH_DEC] = {3'h0, path_dec_i};
      amt8[C_PATH_NDF] = {3'h0, path_ndf_i};
      amt8[C_TUG_INC] = {3'h0, tug_inc_i};
      amt8[C_TUG_DEC] = {3'h0, tug_dec_i};
      amt8[C_TUG_NDF] = tug_ndf_i ? {2'h0, tug_ndf_amt} : 4'h0;
      amt8[C_B3_BLOCK] = {3'h0, b3_block_err_i};
      amt16[C_FAR_END] = 4'h0;
      if (g1_valid_i) begin
         if (st.far_end_block_mode) begin
            amt16[C_FAR_END] = {3'h0, g1_febe_i != 4'h0};
         end else begin
            amt16[C_FAR_END] = g1_febe_i;
         end
      end
      amt16[C_B3_BIT] = b3_bit_errs_i;
      if (st.pattern_analyzer_enable) begin
         amt16[C_LINE_CODE] =
            {3'h0, prbs_error_i & ~analyzer_out_of_lock_i};
      end else begin
         amt16[C_LINE_CODE] = {3'h0, coding_violation_i};
      end
   end

   // Address decode for each counter
   always_comb begin
      lo_hit = 1'b0;
      lo_high = 8'h00;
      for (int i = 0; i < N8; i++) begin
         rd8[i] = cpu_rd_i && cpu_addr_i == CNT8_ADDR[i];
         wr8[i] = cpu_wr_i && cpu_addr_i == CNT8_ADDR[i];
      end
      for (int j = 0; j < N16; j++) begin
         rd_lo[j] = cpu_rd_i && cpu_addr_i == CNT16_ADDR[j];
         rd_hi[j] = cpu_rd_i && cpu_addr_i == CNT16_ADDR[j] + 8'h01;
         wr_lo[j] = cpu_wr_i && cpu_addr_i == CNT16_ADDR[j];
         wr_hi[j] = cpu_wr_i && cpu_addr_i == CNT16_ADDR[j] + 8'h01;
         if (rd_lo[j]) begin
            lo_hit = 1'b1;
            lo_high = c16[j][15:8];
         end
      end
   end

   generate
      for (genvar i = 0; i < N8; i++) begin : g_cnt8
         perf_counter_cell #(.W(8)) u_cell (
            .sys_clk_i(sys_clk_i),
            .sys_rst_i(sys_rst_i),
            .amount_i(amt8[i]),
            .inhibit_i(drop_inhibit),
            .saturate_i(st.clear_on_read_select),
            .hold_i(rd8[i] | wr8[i]),
            .clear_read_i(rd8[i]),
            .clear_all_i(st.global_counter_reset),
            .wr_lo_i(wr8[i]),
            .wr_hi_i(1'b0),
            .wdata_i(cpu_wdata_i),
            .count_o(c8[i])
         );
      end
      for (genvar j = 0; j < N16; j++) begin : g_cnt16
         perf_counter_cell #(.W(16)) u_cell (
            .sys_clk_i(sys_clk_i),
            .sys_rst_i(sys_rst_i),
            .amount_i(amt16[j]),
            .inhibit_i(j != C_LINE_CODE && drop_inhibit),
            .saturate_i(st.clear_on_read_select),
            .hold_i(rd_lo[j] | rd_hi[j] | wr_lo[j] | wr_hi[j]),
            .clear_read_i(rd_lo[j]),
            .clear_all_i(st.global_counter_reset),
            .wr_lo_i(wr_lo[j]),
            .wr_hi_i(wr_hi[j]),
            .wdata_i(cpu_wdata_i),
            .count_o(c16[j])
         );
      end
   endgenerate

   assign leak_period = (st.leak_rate == 8'h00) ? LEAK_MIN_FRAMES
      : {st.leak_rate, 2'h0};

   always_comb begin
      next_st = st;
      next_st.leak_pulse = 1'b0;
      // Reset request lasts exactly one cycle
      next_st.global_counter_reset = 1'b0;
      if (tug_ndf_i) begin
         next_st.tug_prev = tug_ptr_i;
      end
      if (frame_i) begin
         if (st.leak_cnt + 10'h001 >= leak_period) begin
            next_st.leak_cnt = 10'h000;
            next_st.leak_pulse = 1'b1;
         end else begin
            next_st.leak_cnt = st.leak_cnt + 10'h001;
         end
      end
      if (lo_hit) begin
         next_st.shared_high = lo_high;
      end
      if (cpu_wr_i) begin
         case (cpu_addr_i)
            LEAK_ADDR: next_st.leak_rate = cpu_wdata_i;
            CTRL_ADDR: begin
               next_st.clear_on_read_select = cpu_wdata_i[CTRL_CLR_RD_BIT];
               next_st.global_counter_reset =
                  cpu_wdata_i[CTRL_RESET_BIT];
               next_st.far_end_block_mode = cpu_wdata_i[CTRL_FEBE_BLK_BIT];
               next_st.pattern_analyzer_enable =
                  cpu_wdata_i[CTRL_ANA_EN_BIT];
               next_st.external_alarm_select = cpu_wdata_i[CTRL_XALM_BIT];
            end
            // Writes to the shared byte are dropped
            SHARED_ADDR: next_st.shared_high = st.shared_high;
            default: next_st.leak_rate = st.leak_rate;
         endcase
      end
      if (cpu_rd_i) begin
         next_st.rdata = 8'h00;
         for (int i = 0; i < N8; i++) begin
            if (rd8[i]) begin
               next_st.rdata = c8[i];
            end
         end
         for (int j = 0; j < N16; j++) begin
            if (rd_lo[j]) begin
               next_st.rdata = c16[j][7:0];
            end
            if (rd_hi[j]) begin
               next_st.rdata = c16[j][15:8];
            end
         end
         case (cpu_addr_i)
            LEAK_ADDR: next_st.rdata = st.leak_rate;
            CTRL_ADDR: begin
               next_st.rdata[CTRL_CLR_RD_BIT] = st.clear_on_read_select;
               next_st.rdata[CTRL_RESET_BIT] = st.global_counter_reset;
               next_st.rdata[CTRL_FEBE_BLK_BIT] = st.far_end_block_mode;
               next_st.rdata[CTRL_ANA_EN_BIT] = st.pattern_analyzer_enable;
               next_st.rdata[CTRL_XALM_BIT] = st.external_alarm_select;
            end
            SHARED_ADDR: next_st.rdata = st.shared_high;
            default: next_st.rdata = next_st.rdata;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st <= '0;
         st.leak_rate <= LEAK_RESET_VAL;
         st.tug_prev <= TUG_PTR_RESET_VAL;
         st.clear_on_read_select <= CTRL_RESET_VAL[CTRL_CLR_RD_BIT];
         st.far_end_block_mode <= CTRL_RESET_VAL[CTRL_FEBE_BLK_BIT];
         st.pattern_analyzer_enable <= CTRL_RESET_VAL[CTRL_ANA_EN_BIT];
         st.external_alarm_select <= CTRL_RESET_VAL[CTRL_XALM_BIT];
      end else begin
         st <= next_st;
      end
   end

   assign cpu_rdata_o = st.rdata;
   assign fifo_leak_o = st.leak_pulse;

   // Helper terms for the checks below
   logic quiet_frame;
   assign quiet_frame = !st.global_counter_reset && !cpu_wr_i
      && !drop_inhibit;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_shared_copy: assert property (
      lo_hit |=> st.shared_high == $past(lo_high))
      else $error("shared high byte not loaded on low byte read");

   a_shared_keep: assert property (
      !lo_hit |=> $stable(st.shared_high))
      else $error("shared high byte changed without low byte read");

   // Held event lands on top of the cleared or kept value
   a_read_held: assert property (
      rd8[C_PATH_NDF] && path_ndf_i && quiet_frame
      ##1 !path_ndf_i && !rd8[C_PATH_NDF] && quiet_frame
      |=> c8[C_PATH_NDF] == 8'h01 + (st.clear_on_read_select ? 8'h00
      : $past(c8[C_PATH_NDF], 2)))
      else $error("event during read was lost");

   a_read_clear: assert property (
      rd8[C_PATH_DEC] && st.clear_on_read_select
      && !st.global_counter_reset |=> c8[C_PATH_DEC] == 8'h00)
      else $error("counter not cleared by read in clear on read mode");

   a_roll_wrap: assert property (
      c8[C_PATH_INC] == 8'hFF && path_inc_i && !rd8[C_PATH_INC]
      && !$past(rd8[C_PATH_INC] || wr8[C_PATH_INC])
      && !st.clear_on_read_select && quiet_frame
      |=> c8[C_PATH_INC] == 8'h00)
      else $error("rolling counter did not wrap");

   a_reset_pulse: assert property (
      cpu_wr_i && cpu_addr_i == CTRL_ADDR && cpu_wdata_i[CTRL_RESET_BIT]
      |=> st.global_counter_reset ##1
      !st.global_counter_reset && c8[C_B3_BLOCK] == 8'h00)
      else $error("global reset did not clear or self clear");

   a_drop_inhibit: assert property (
      drop_inhibit && !st.global_counter_reset && !cpu_wr_i
      && !cpu_rd_i && $past(!cpu_rd_i && !cpu_wr_i)
      |=> $stable(c8[C_B3_BLOCK]))
      else $error("drop counter moved under alarm");

   a_tug_skip: assert property (
      tug_ndf_i && st.tug_prev == TUG_PTR_192 && tug_ptr_i == TUG_PTR_194
      && !tug_dec_i |-> amt8[C_TUG_NDF] == 4'h0)
      else $error("new pointer counted for skipped pair");

   a_leak_zero: assert property (
      st.leak_rate == 8'h00 && frame_i && st.leak_cnt == 10'h001
      |=> fifo_leak_o)
      else $error("leak not every other frame at rate zero");

   c_sixteen_read: cover property (
      rd_lo[C_FAR_END] ##3 cpu_rd_i && cpu_addr_i == SHARED_ADDR);
   c_held_event: cover property (rd8[C_PATH_NDF] && path_ndf_i);
   c_saturate: cover property (
      st.clear_on_read_select && c8[C_PATH_DEC] == 8'hFF && path_dec_i);
   c_inhibited: cover property (drop_inhibit && b3_block_err_i);

endmodule
`default_nettype wire

// *** rtl/perf_bank_pkg.sv ***
// Register map, field positions and constants of the performance counter bank
package perf_bank_pkg;

   // Register offsets on the microprocessor port
   localparam logic [7:0] FRAME_ADDR = 8'hA0;
   localparam logic [7:0] SPARE_ADDR = 8'hA1;
   localparam logic [7:0] LEAK_ADDR = 8'hA2;
   localparam logic [7:0] CTRL_ADDR = 8'hB0;
   localparam logic [7:0] SHARED_ADDR = 8'hFF;

   localparam int N8 = 8;
   localparam int N16 = 3;

   // 8-bit counters in address order
   localparam logic [7:0] CNT8_ADDR [N8] = '{
      8'hA0, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9};
   // Low byte address of each 16-bit counter; high byte at +1
   localparam logic [7:0] CNT16_ADDR [N16] = '{8'hAA, 8'hAC, 8'hAE};

   // Indices into the 8-bit counter set
   localparam int C_FRAME = 0;
   localparam int C_PATH_INC = 1;
   localparam int C_PATH_DEC = 2;
   localparam int C_PATH_NDF = 3;
   localparam int C_TUG_INC = 4;
   localparam int C_TUG_DEC = 5;
   localparam int C_TUG_NDF = 6;
   localparam int C_B3_BLOCK = 7;
   // Indices into the 16-bit counter set
   localparam int C_FAR_END = 0;
   localparam int C_B3_BIT = 1;
   localparam int C_LINE_CODE = 2;

   // Control register fields
   localparam int CTRL_CLR_RD_BIT = 0;
   localparam int CTRL_RESET_BIT = 1;
   localparam int CTRL_FEBE_BLK_BIT = 2;
   localparam int CTRL_ANA_EN_BIT = 3;
   localparam int CTRL_XALM_BIT = 4;

   // Reset values
   localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
   localparam logic [7:0] LEAK_RESET_VAL = 8'h00;
   localparam logic [9:0] TUG_PTR_RESET_VAL = 10'h000;

   // TUG-3 pointer values with the odd new-pointer count behaviour
   localparam logic [9:0] TUG_PTR_192 = 10'h0C0;
   localparam logic [9:0] TUG_PTR_193 = 10'h0C1;
   localparam logic [9:0] TUG_PTR_194 = 10'h0C2;
   localparam logic [9:0] TUG_PTR_195 = 10'h0C3;

   // Leak spacing with a zero rate: every other frame
   localparam logic [9:0] LEAK_MIN_FRAMES = 10'h002;

endpackage

// *** rtl/perf_counter_cell.sv ***
// One performance counter with read hold, saturation and byte writes
`timescale 1ns/1ns
`default_nettype none
module perf_counter_cell
   import perf_bank_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] amount_i,
   input wire logic inhibit_i,
   input wire logic saturate_i,
   input wire logic hold_i,
   input wire logic clear_read_i,
   input wire logic clear_all_i,
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic [7:0] wdata_i,
   output logic [W-1:0] count_o
);

   typedef struct packed {
      logic [W-1:0] count;
      logic [4:0] pend;
   } cell_state_t;

   cell_state_t st, next_st;

   always_comb begin
      logic [3:0] add;
      logic [W:0] total;
      add = inhibit_i ? 4'h0 : amount_i;
      total = '0;
      next_st = st;
      if (clear_all_i) begin
         next_st.count = '0;
         next_st.pend = 5'h00;
      end else if (hold_i) begin
         // Events during an access wait for the next cycle without an access
         next_st.pend = st.pend + 5'(add);
         if (clear_read_i && saturate_i) begin
            next_st.count = '0;
         end
         if (wr_lo_i) begin
            next_st.count = (st.count & ~W'(8'hFF)) | W'(wdata_i);
         end
         if (wr_hi_i) begin
            next_st.count = (st.count & W'(8'hFF)) | (W'(wdata_i) << 8);
         end
      end else begin
         total = (W+1)'(st.count) + (W+1)'(st.pend) + (W+1)'(add);
         if (saturate_i && total[W]) begin
            next_st.count = '1;
         end else begin
            next_st.count = total[W-1:0];
         end
         next_st.pend = 5'h00;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count_o = st.count;

endmodule
`default_nettype wire

// *** tb/path_performance_counter_bank_tb_top.sv ***
// Self-checking bench for the performance counter bank
`timescale 1ns/1ns
`default_nettype none
module path_performance_counter_bank_tb_top
   import perf_bank_pkg::*;
;
   typedef struct packed {
      logic [7:0] a;
      logic [3:0] i;
      logic [3:0] n;
      logic [7:0] e;
   } row_t;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [10:0] ev = 11'h000;
   logic [6:0] alm = 7'h00;
   logic [9:0] ptr = 10'h000;
   logic [3:0] febe = 4'h0;
   logic [3:0] b3e = 4'h0;
   logic out_of_lock = 1'b0;
   logic [7:0] rdata;
   logic leak;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int leaks = 0;
   // Event index, burst length, expected count; g1 carries 3 errors
   row_t rows [10] = '{'{8'hA0, 4'h0, 4'h3, 8'h03},
      '{8'hA3, 4'h1, 4'h2, 8'h02}, '{8'hA4, 4'h2, 4'h4, 8'h04},
      '{8'hA5, 4'h3, 4'h1, 8'h01}, '{8'hA6, 4'h4, 4'h5, 8'h05},
      '{8'hA7, 4'h5, 4'h2, 8'h02}, '{8'hA8, 4'h6, 4'h3, 8'h03},
      '{8'hA9, 4'h7, 4'h6, 8'h06}, '{8'hAA, 4'h8, 4'h2, 8'h06},
      '{8'hAE, 4'h9, 4'h7, 8'h07}};

   path_performance_counter_bank dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .cpu_addr_i(addr), .cpu_wdata_i(wdata),
      .cpu_wr_i(wr), .cpu_rd_i(rd),
      .frame_i(ev[0]), .path_inc_i(ev[1]), .path_dec_i(ev[2]),
      .path_ndf_i(ev[3]), .tug_inc_i(ev[4]), .tug_dec_i(ev[5]),
      .tug_ndf_i(ev[6]), .tug_ptr_i(ptr), .b3_block_err_i(ev[7]),
      .g1_valid_i(ev[8]), .g1_febe_i(febe), .b3_bit_errs_i(b3e),
      .coding_violation_i(ev[9]), .prbs_error_i(ev[10]),
      .analyzer_out_of_lock_i(out_of_lock),
      .drop_clock_loss_alarm_i(alm[0]),
      .drop_path_start_loss_alarm_i(alm[1]),
      .tug_loss_of_pointer_i(alm[2]), .tug_path_ais_i(alm[3]),
      .e1_ais_i(alm[4]), .external_status_input_i(alm[5]),
      .path_alarm_input_i(alm[6]),
      .cpu_rdata_o(rdata), .fifo_leak_o(leak)
   );

   always #4 sys_clk_i = ~sys_clk_i;

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // A hung handshake would stall the sequence forever
   always @(posedge sys_clk_i) begin
      cycles++;
      if (leak === 1'b1) begin
         leaks++;
      end
      if (cycles == 30000) begin
         mismatches++;
         results();
      end
   end

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a, input logic [7:0] e,
                      input string n);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      @(posedge sys_clk_i);
      #1 chk(n, e, rdata);
   endtask

   // Holds one event input high for n edges
   task automatic pulse(input int i, input int n);
      @(posedge sys_clk_i);
      ev[i] <= 1'b1;
      repeat (n) @(posedge sys_clk_i);
      ev[i] <= 1'b0;
   endtask

   initial begin
      logic blk;
      string nm;
      int l0;
      logic [9:0] pl [6];
      pl = '{TUG_PTR_192, TUG_PTR_194, TUG_PTR_192, TUG_PTR_193,
             TUG_PTR_195, TUG_PTR_193};
      repeat (4) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      febe <= 4'h3;
      foreach (rows[k]) begin
         nm = $sformatf("cnt %h", rows[k].a);
         pulse(rows[k].i, rows[k].n);
         rd8(rows[k].a, rows[k].e, nm);
      end
      rd8(SHARED_ADDR, 8'h00, "shared after AA");
      wr8(SPARE_ADDR, 8'h5A);
      rd8(SPARE_ADDR, 8'h00, "spare");
      wr8(8'h10, 8'h5A);
      rd8(8'h10, 8'h00, "unmapped");
      wr8(8'hAA, 8'h34);
      wr8(8'hAB, 8'h12);
      wr8(8'hAC, 8'h00);
      wr8(8'hAD, 8'h56);
      rd8(8'hAA, 8'h34, "far end low");
      wr8(SHARED_ADDR, 8'h77);
      rd8(SHARED_ADDR, 8'h12, "shared far end");
      rd8(8'hAA, 8'h34, "far end low again");
      rd8(8'hAC, 8'h00, "bit low");
      rd8(SHARED_ADDR, 8'h56, "shared bit");
      rd8(8'hAB, 8'h12, "far end high");
      // Bit differences as a level over two cycles
      @(posedge sys_clk_i);
      b3e <= 4'h5;
      repeat (2) @(posedge sys_clk_i);
      b3e <= 4'h0;
      rd8(8'hAC, 8'h0A, "bit diffs");
      wr8(8'hA3, 8'hFF);
      pulse(1, 2);
      rd8(8'hA3, 8'h01, "wrap");
      rd8(8'hA3, 8'h01, "wrap kept");
      wr8(CTRL_ADDR, 8'h01);
      wr8(8'hA4, 8'hFE);
      pulse(2, 3);
      rd8(8'hA4, 8'hFF, "saturate");
      rd8(8'hA4, 8'h00, "cleared");
      wr8(8'hAE, 8'hFF);
      wr8(8'hAF, 8'hFF);
      pulse(9, 1);
      rd8(8'hAE, 8'hFF, "sat16 low");
      rd8(SHARED_ADDR, 8'hFF, "sat16 high");
      rd8(8'hAE, 8'h00, "sat16 cleared");
      // Event arrives in the very cycle of a clearing read
      wr8(8'hA5, 8'h07);
      @(posedge sys_clk_i);
      addr <= 8'hA5;
      rd <= 1'b1;
      ev[3] <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      ev[3] <= 1'b0;
      @(posedge sys_clk_i);
      #1 chk("read with event", 8'h07, rdata);
      rd8(8'hA5, 8'h01, "held event");
      wr8(8'hA9, 8'h33);
      wr8(CTRL_ADDR, 8'h02);
      rd8(CTRL_ADDR, 8'h00, "reset bit");
      rd8(8'hA9, 8'h00, "global 8");
      rd8(8'hAA, 8'h00, "global 16");
      for (int s = 0; s < 2; s++) begin
         wr8(CTRL_ADDR, 8'(s << CTRL_XALM_BIT));
         for (int j = 0; j < 7; j++) begin
            wr8(8'hA9, 8'h00);
            @(posedge sys_clk_i);
            alm[j] <= 1'b1;
            pulse(7, 1);
            pulse(9, 1);
            alm[j] <= 1'b0;
            blk = (j < 4) || (s == 0 ? j == 4 : j > 4);
            nm = $sformatf("inh %0d %0d", s, j);
            rd8(8'hA9, {7'h00, !blk}, nm);
         end
      end
      rd8(8'hAE, 8'h0E, "line side");
      wr8(CTRL_ADDR, 8'h00);
      wr8(8'hA8, 8'h00);
      foreach (pl[k]) begin
         @(posedge sys_clk_i);
         ptr <= pl[k];
         pulse(6, 1);
      end
      rd8(8'hA8, 8'h06, "tug new ptr");
      wr8(CTRL_ADDR, 8'h04);
      wr8(8'hAA, 8'h00);
      @(posedge sys_clk_i);
      febe <= 4'h0;
      pulse(8, 1);
      febe <= 4'h9;
      pulse(8, 1);
      febe <= 4'hF;
      pulse(8, 1);
      rd8(8'hAA, 8'h02, "far end blocks");
      wr8(CTRL_ADDR, 8'h08);
      wr8(8'hAE, 8'h00);
      pulse(9, 1);
      pulse(10, 1);
      out_of_lock <= 1'b1;
      pulse(10, 1);
      out_of_lock <= 1'b0;
      rd8(8'hAE, 8'h01, "prbs in lock");
      // Second reset mid-run also restarts the leak timer
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      rd8(CTRL_ADDR, CTRL_RESET_VAL, "ctrl reset");
      rd8(LEAK_ADDR, LEAK_RESET_VAL, "leak reset");
      rd8(8'hA8, 8'h00, "count reset");
      l0 = leaks;
      repeat (8) pulse(0, 1);
      repeat (4) @(posedge sys_clk_i);
      chk("leak rate 0", 8'h04, 8'(leaks - l0));
      wr8(LEAK_ADDR, 8'h01);
      rd8(LEAK_ADDR, 8'h01, "leak reg");
      l0 = leaks;
      repeat (8) pulse(0, 1);
      repeat (4) @(posedge sys_clk_i);
      chk("leak rate 1", 8'h02, 8'(leaks - l0));
      results();
   end
endmodule
`default_nettype wire
